// *** src/dsr_codec.sv ***
// Purpose: Status word upper byte and reference / actual value scaling for a drive
// Assumes: Drive-side inputs are logic on pclk; APB slave with no wait states
// Notes:   Commands to the drive are in native units; gains are Q16 fixed point
`timescale 1ns/100ps
// How it works
// - Bit 8 set when actual within tolerance
// - Bit 10: target reached, or speed limit
// - Bit 11 shows valid homing in positioning
// - Bits 14, 15 chosen by vendor selectors
// - Speed references: sign plus 15/31 bits
// - Negative references use two's complement
// - Short reference 4000h is full maximum
// - Long reference 4000 0000h is full maximum
// - Position references: signed 32-bit words
// - Position setpoint scaled by position parameters
// - Velocity setpoint scaled by velocity parameters
// - Actual words 16/32 bits, source selectable
// - Short actual speed 4000h equals maximum
// - Long actual speed 4000 0000h equals maximum
// - Actual position uses position scaling parameters; code scales it by position_actual_gain
// - Control word forwarded, Status word returned
// - Fieldbus control accepted only when selected
module dsr_codec
    import dsr_pkg::*;
#(
    parameter int MON_COUNT = 4
) (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic [7:0]            paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Drive feedback
    input  wire logic [31:0]           measured_speed_native,
    input  wire logic [31:0]           drive_position_raw,
    input  wire logic [MON_COUNT*32-1:0] monitor_values,
    input  wire logic                  target_reached,
    input  wire logic                  homing_valid,
    input  wire logic                  traverse_ack,
    input  wire logic                  drive_stopped,
    input  wire logic                  remote_location,
    input  wire logic [7:0]            status_low,
    input  wire logic [7:0]            vendor_sources,
    // Drive commands
    output logic      [15:0]           control_word,
    output logic      [31:0]           speed_command,
    output logic      [31:0]           position_command,
    output logic      [31:0]           velocity_command,
    output logic                       positioning_mode,
    output logic                       fieldbus_control,
    output logic                       within_tolerance_flag,
    output logic      [15:0]           status_word
);
    if (MON_COUNT < 1 || MON_COUNT > (1 << ACT_SEL_W)) begin : g_bad_mon
        $error("dsr_codec: MON_COUNT out of range");
    end

    // Software-visible registers
    logic [15:0] control_reg;
    logic [15:0] speed_setpoint_short_alt;
    logic [31:0] speed_setpoint_long;
    logic [31:0] position_setpoint;
    logic [31:0] velocity_setpoint;
    logic [31:0] config_reg;
    logic [31:0] max_reference;
    logic [31:0] tolerance;
    logic [31:0] supervision_limit;
    logic [31:0] position_integer_scale_param;
    logic [31:0] velocity_integer_scale_param;
    logic [31:0] actual_gain;
    logic [31:0] position_actual_gain;
    logic [15:0] measured_speed_short;
    logic [31:0] measured_speed_long;
    logic [31:0] measured_position;

    // Internal signals
    logic        setup;
    logic        wr_en;
    logic        fb_ok;
    logic        pos_mode;
    logic [31:0] ref_short_ext;
    logic [31:0] cmd_short;
    logic [31:0] cmd_long;
    logic [31:0] cmd_pos;
    logic [31:0] cmd_vel;
    logic [31:0] act_scaled;
    logic [31:0] pos_scaled;
    logic [31:0] monitor_pick;
    logic [ACT_SEL_W-1:0] act_sel;
    logic [32:0] err_diff;
    logic [32:0] err_abs;
    logic [32:0] speed_abs;
    logic        limit_hit;
    logic [15:0] next_status;
    logic [31:0] next_rdata;
    logic        next_err;

    assign setup    = psel & ~penable;
    assign wr_en    = psel & penable & pwrite;
    assign fb_ok    = config_reg[CFG_FB_SOURCE];
    assign pos_mode = config_reg[CFG_POS_MODE];
    assign pready   = 1'b1;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Fieldbus command words, taken only while the fieldbus is the control source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_reg              <= RST_ZERO[15:0];
            speed_setpoint_short_alt <= RST_ZERO[15:0];
            speed_setpoint_long      <= RST_ZERO;
            position_setpoint        <= RST_ZERO;
            velocity_setpoint        <= RST_ZERO;
        end else if (wr_en && fb_ok) begin
            unique case (paddr)
                OFS_CONTROL: control_reg <= 16'(merge(32'(control_reg), pwdata, pstrb));
                OFS_REF_SHORT:
                    speed_setpoint_short_alt <=
                        16'(merge(32'(speed_setpoint_short_alt), pwdata, pstrb));
                OFS_REF_LONG:
                    speed_setpoint_long <= merge(speed_setpoint_long, pwdata, pstrb);
                OFS_POS_REF:
                    position_setpoint <= merge(position_setpoint, pwdata, pstrb);
                OFS_VEL_REF:
                    velocity_setpoint <= merge(velocity_setpoint, pwdata, pstrb);
                default: ;
            endcase
        end
    end

    // Drive parameters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_reg                   <= RST_ZERO;
            max_reference                <= RST_MAX_REF;
            tolerance                    <= RST_ZERO;
            supervision_limit            <= RST_ZERO;
            position_integer_scale_param <= RST_UNITY;
            velocity_integer_scale_param <= RST_UNITY;
            actual_gain                  <= RST_UNITY;
            position_actual_gain         <= RST_UNITY;
        end else if (wr_en) begin
            unique case (paddr)
                OFS_CONFIG:      config_reg <= merge(config_reg, pwdata, pstrb) & CFG_USED_MASK;
                OFS_MAX_REF:     max_reference <= merge(max_reference, pwdata, pstrb);
                OFS_TOLERANCE:   tolerance <= merge(tolerance, pwdata, pstrb);
                OFS_SUPERVISION: supervision_limit <= merge(supervision_limit, pwdata, pstrb);
                OFS_POS_SCALE:
                    position_integer_scale_param <=
                        merge(position_integer_scale_param, pwdata, pstrb);
                OFS_VEL_SCALE:
                    velocity_integer_scale_param <=
                        merge(velocity_integer_scale_param, pwdata, pstrb);
                OFS_ACT_GAIN:    actual_gain <= merge(actual_gain, pwdata, pstrb);
                OFS_POS_ACT_GAIN:
                    position_actual_gain <= merge(position_actual_gain, pwdata, pstrb);
                default: ;
            endcase
        end
    end

    // Reference scaling into native drive units
    assign ref_short_ext = {{16{speed_setpoint_short_alt[15]}}, speed_setpoint_short_alt};

    dsr_scale #(.SHIFT(REF_SHORT_SHIFT)) u_ref_short (
        .pclk    (pclk),
        .presetn (presetn),
        .value   (ref_short_ext),
        .gain    (max_reference),
        .result  (cmd_short)
    );

    dsr_scale #(.SHIFT(REF_LONG_SHIFT)) u_ref_long (
        .pclk    (pclk),
        .presetn (presetn),
        .value   (speed_setpoint_long),
        .gain    (max_reference),
        .result  (cmd_long)
    );

    dsr_scale #(.SHIFT(GAIN_SHIFT)) u_pos_ref (
        .pclk    (pclk),
        .presetn (presetn),
        .value   (position_setpoint),
        .gain    (position_integer_scale_param),
        .result  (cmd_pos)
    );

    dsr_scale #(.SHIFT(GAIN_SHIFT)) u_vel_ref (
        .pclk    (pclk),
        .presetn (presetn),
        .value   (velocity_setpoint),
        .gain    (velocity_integer_scale_param),
        .result  (cmd_vel)
    );

    // Actual value scaling back to fieldbus words
    assign act_sel = config_reg[CFG_ACT_SEL +: ACT_SEL_W];

    always_comb begin
        monitor_pick = monitor_values[31:0];
        for (int i = 0; i < MON_COUNT; i++) begin
            if (act_sel == i[ACT_SEL_W-1:0]) begin
                monitor_pick = monitor_values[i*32 +: 32];
            end
        end
    end

    dsr_scale #(.SHIFT(GAIN_SHIFT)) u_act (
        .pclk    (pclk),
        .presetn (presetn),
        .value   (monitor_pick),
        .gain    (actual_gain),
        .result  (act_scaled)
    );

    dsr_scale #(.SHIFT(GAIN_SHIFT)) u_pos_act (
        .pclk    (pclk),
        .presetn (presetn),
        .value   (drive_position_raw),
        .gain    (position_actual_gain),
        .result  (pos_scaled)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            measured_speed_short <= RST_ZERO[15:0];
            measured_speed_long  <= RST_ZERO;
            measured_position    <= RST_ZERO;
        end else begin
            measured_speed_short <= act_scaled[31:16];
            measured_speed_long  <= act_scaled;
            measured_position    <= pos_scaled;
        end
    end

    // Commands to the drive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_word     <= RST_ZERO[15:0];
            speed_command    <= RST_ZERO;
            position_command <= RST_ZERO;
            velocity_command <= RST_ZERO;
            positioning_mode <= 1'b0;
            fieldbus_control <= 1'b0;
        end else begin
            control_word     <= fb_ok ? control_reg : RST_ZERO[15:0];
            speed_command    <= config_reg[CFG_REF_LONG] ? cmd_long : cmd_short;
            position_command <= cmd_pos;
            velocity_command <= cmd_vel;
            positioning_mode <= pos_mode;
            fieldbus_control <= fb_ok;
        end
    end

    // Tolerance and supervision checks
    always_comb begin
        if (pos_mode) begin
            err_diff = {position_command[31], position_command}
                     - {measured_position[31], measured_position};
        end else begin
            err_diff = {speed_command[31], speed_command}
                     - {measured_speed_native[31], measured_speed_native};
        end
        err_abs   = err_diff[32] ? 33'h0 - err_diff : err_diff;
        speed_abs = measured_speed_native[31]
                  ? 33'h0 - {1'b1, measured_speed_native}
                  : {1'b0, measured_speed_native};
        limit_hit = speed_abs >= {1'b0, supervision_limit};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            within_tolerance_flag <= 1'b0;
        end else begin
            within_tolerance_flag <= err_abs <= {1'b0, tolerance};
        end
    end

    // Status word assembly
    always_comb begin
        next_status               = {8'h00, status_low};
        next_status[ST_TOLERANCE] = within_tolerance_flag;
        next_status[ST_REMOTE]    = remote_location;
        next_status[ST_LIMIT]     = pos_mode ? target_reached : limit_hit;
        next_status[ST_HOMED]     = pos_mode ? homing_valid
                                  : vendor_sources[config_reg[CFG_VSEL11 +: VSEL_W]];
        next_status[ST_TRAV_ACK]  = pos_mode ? traverse_ack
                                  : vendor_sources[config_reg[CFG_VSEL12 +: VSEL_W]];
        next_status[ST_STOPPED]   = pos_mode ? drive_stopped
                                  : vendor_sources[config_reg[CFG_VSEL13 +: VSEL_W]];
        next_status[ST_VEND14]    = vendor_sources[config_reg[CFG_VSEL14 +: VSEL_W]];
        next_status[ST_VEND15]    = vendor_sources[config_reg[CFG_VSEL15 +: VSEL_W]];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_word <= RST_ZERO[15:0];
        end else begin
            status_word <= next_status;
        end
    end

    // Read decode, captured in the setup cycle
    always_comb begin
        next_rdata = RST_ZERO;
        next_err   = 1'b0;
        unique case (paddr)
            OFS_CONTROL:      next_rdata = {16'h0000, control_reg};
            OFS_REF_SHORT:    next_rdata = {16'h0000, speed_setpoint_short_alt};
            OFS_REF_LONG:     next_rdata = speed_setpoint_long;
            OFS_POS_REF:      next_rdata = position_setpoint;
            OFS_VEL_REF:      next_rdata = velocity_setpoint;
            OFS_CONFIG:       next_rdata = config_reg;
            OFS_MAX_REF:      next_rdata = max_reference;
            OFS_TOLERANCE:    next_rdata = tolerance;
            OFS_SUPERVISION:  next_rdata = supervision_limit;
            OFS_POS_SCALE:    next_rdata = position_integer_scale_param;
            OFS_VEL_SCALE:    next_rdata = velocity_integer_scale_param;
            OFS_ACT_GAIN:     next_rdata = actual_gain;
            OFS_POS_ACT_GAIN: next_rdata = position_actual_gain;
            OFS_STATUS:       next_rdata = {16'h0000, status_word};
            OFS_ACT_SHORT:    next_rdata = {16'h0000, measured_speed_short};
            OFS_ACT_LONG:     next_rdata = measured_speed_long;
            OFS_ACT_POS:      next_rdata = measured_position;
            default:          next_err   = 1'b1;
        endcase
        if (pwrite && paddr >= OFS_STATUS) begin
            next_err = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= RST_ZERO;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? RST_ZERO : next_rdata;
            pslverr <= next_err;
        end else if (!psel) begin
            prdata  <= RST_ZERO;
            pslverr <= 1'b0;
        end
    end
endmodule

// *** src/dsr_pkg.sv ***
// Purpose: Shared constants for the drive status and reference codec
// Assumes: APB register map, 32-bit words, one aligned word per register
// Notes:   Offsets are byte addresses; full-scale words mark 100 % of maximum reference
package dsr_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CONTROL      = 8'h00;
    localparam logic [7:0] OFS_REF_SHORT    = 8'h04;
    localparam logic [7:0] OFS_REF_LONG     = 8'h08;
    localparam logic [7:0] OFS_POS_REF      = 8'h0c;
    localparam logic [7:0] OFS_VEL_REF      = 8'h10;
    localparam logic [7:0] OFS_CONFIG       = 8'h14;
    localparam logic [7:0] OFS_MAX_REF      = 8'h18;
    localparam logic [7:0] OFS_TOLERANCE    = 8'h1c;
    localparam logic [7:0] OFS_SUPERVISION  = 8'h20;
    localparam logic [7:0] OFS_POS_SCALE    = 8'h24;
    localparam logic [7:0] OFS_VEL_SCALE    = 8'h28;
    localparam logic [7:0] OFS_ACT_GAIN     = 8'h2c;
    localparam logic [7:0] OFS_POS_ACT_GAIN = 8'h30;
    localparam logic [7:0] OFS_STATUS       = 8'h34;
    localparam logic [7:0] OFS_ACT_SHORT    = 8'h38;
    localparam logic [7:0] OFS_ACT_LONG     = 8'h3c;
    localparam logic [7:0] OFS_ACT_POS      = 8'h40;

    // Configuration register fields
    localparam int CFG_POS_MODE  = 0;
    localparam int CFG_FB_SOURCE = 1;
    localparam int CFG_REF_LONG  = 2;
    localparam int CFG_ACT_SEL   = 8;
    localparam int ACT_SEL_W     = 2;
    localparam int CFG_VSEL11    = 16;
    localparam int CFG_VSEL12    = 19;
    localparam int CFG_VSEL13    = 22;
    localparam int CFG_VSEL14    = 25;
    localparam int CFG_VSEL15    = 28;
    localparam int VSEL_W        = 3;
    localparam logic [31:0] CFG_USED_MASK = 32'h7fff_0307;

    // Status word bit positions
    localparam int ST_TOLERANCE = 8;
    localparam int ST_REMOTE    = 9;
    localparam int ST_LIMIT     = 10;
    localparam int ST_HOMED     = 11;
    localparam int ST_TRAV_ACK  = 12;
    localparam int ST_STOPPED   = 13;
    localparam int ST_VEND14    = 14;
    localparam int ST_VEND15    = 15;

    // Scaling: 4000h and 4000 0000h are 100 % of maximum reference
    localparam logic [15:0] REF_SHORT_FULL = 16'h4000;
    localparam logic [31:0] REF_LONG_FULL  = 32'h4000_0000;
    localparam int REF_SHORT_SHIFT = 14;
    localparam int REF_LONG_SHIFT  = 30;
    localparam int GAIN_SHIFT      = 16;

    // Reset values
    localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
    localparam logic [31:0] RST_MAX_REF  = 32'h0000_0000;
    localparam logic [31:0] RST_UNITY    = 32'h0001_0000;
endpackage

// *** src/dsr_scale.sv ***
// Purpose: Signed value times unsigned gain, shifted right and saturated to 32 bits
// Assumes: Same clock as the caller; one cycle of latency
// Notes:   Result comes from a register
`timescale 1ns/100ps
module dsr_scale #(
    parameter int SHIFT = 16
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Operands
    input  wire logic [31:0] value,
    input  wire logic [31:0] gain,
    // Scaled result
    output logic      [31:0] result
);
    if (SHIFT < 0 || SHIFT > 62) begin : g_bad_shift
        $error("dsr_scale: SHIFT out of range");
    end

    logic signed [64:0] product;
    logic signed [64:0] shifted;
    logic        [31:0] next_result;

    always_comb begin
        product = $signed(value) * $signed({1'b0, gain});
        shifted = product >>> SHIFT;
        if (shifted > 65'sh0_7fff_ffff) begin
            next_result = 32'h7fff_ffff;
        end else if (shifted < -65'sh0_8000_0000) begin
            next_result = 32'h8000_0000;
        end else begin
            next_result = shifted[31:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result <= 32'h0000_0000;
        end else begin
            result <= next_result;
        end
    end
endmodule

// *** testbench/dsr_master.sv ***
// Purpose: Bus master standing in for the fieldbus master
// Assumes: Slave answers when pready is high at a rising edge
// Notes:   Write data is inverted once released
`timescale 1ns/100ps
module dsr_master (
    // Clock and answer
    input wire logic        pclk,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Request
    output logic     [7:0]  paddr,
    output logic            psel,
    output logic            penable,
    output logic            pwrite,
    output logic     [31:0] pwdata
);
    initial begin
        {paddr, psel, penable, pwrite, pwdata} = '0;
    end
    // One transfer: setup, then access until pready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule

// *** testbench/dsr_monitor.sv ***
// Purpose: Checker for the codec status word and bus refusals
// Assumes: Bound to dsr_codec, sees its ports only
// Notes:   Status inputs land in status_word one edge later
`timescale 1ns/100ps
module dsr_monitor
    import dsr_pkg::*;
(
    // Clock, reset and bus
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pslverr,
    // Drive side
    input wire logic        target_reached,
    input wire logic        homing_valid,
    input wire logic        remote_location,
    input wire logic [7:0]  status_low,
    input wire logic        positioning_mode,
    input wire logic        fieldbus_control,
    input wire logic        within_tolerance_flag,
    input wire logic [15:0] control_word,
    input wire logic [15:0] status_word
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_tol_bit: assert property ($past(presetn) |-> status_word[8] == $past(within_tolerance_flag))
        else $error("status bit 8 differs from tolerance flag");
    a_remote_bit: assert property ($past(presetn) |-> status_word[9] == $past(remote_location))
        else $error("status bit 9 differs from remote input");
    a_low_byte: assert property ($past(presetn) |-> status_word[7:0] == $past(status_low))
        else $error("status low byte not passed");
    a_target_bit: assert property ($past(positioning_mode) && positioning_mode
        |-> status_word[10] == $past(target_reached)) else $error("bit 10 not target reached");
    a_homed_bit: assert property ($past(positioning_mode) && positioning_mode
        |-> status_word[11] == $past(homing_valid)) else $error("bit 11 not homing valid");
    a_ctrl_gated: assert property (!fieldbus_control && !$past(fieldbus_control)
        |-> control_word == 16'h0) else $error("control word passed without fieldbus source");
    a_ro_refused: assert property (psel && penable && pwrite && paddr >= OFS_STATUS
        && paddr <= OFS_ACT_POS |-> pslverr) else $error("read-only write not refused");
    a_unmapped_err: assert property (psel && penable && paddr > OFS_ACT_POS |-> pslverr)
        else $error("unmapped access not refused");
    cover property (positioning_mode && status_word[11]);
    cover property (status_word[8]);
    cover property (psel && penable && pslverr);
endmodule
bind dsr_codec dsr_monitor i_mon (.*);

// *** testbench/testbench.sv ***
// Purpose: Self-checking bench for the drive status and reference codec
// Assumes: Commands follow a register write two edges later
// Notes:   Rows cover scaling; hand tests cover status, gating, refusals, reset
`timescale 1ns/100ps
module testbench
    import dsr_pkg::*;
;
    typedef struct {
        logic [31:0] cfg;
        logic [7:0]  off;
        logic [31:0] data;
        int          sel;
        logic [31:0] exp;
    } dsr_row_s;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]   paddr, status_low, vendor_sources;
    logic [31:0]  pwdata, prdata, q, measured_speed_native, drive_position_raw;
    logic [31:0]  speed_command, position_command, velocity_command;
    logic [127:0] monitor_values;
    logic [15:0]  control_word, status_word;
    logic         target_reached, homing_valid, traverse_ack, drive_stopped, remote_location;
    logic         positioning_mode, fieldbus_control, within_tolerance_flag;
    logic [3:0]   pstrb;
    int           errors, n_checks;
    dsr_row_s     rows[8] = '{
        '{32'h2, OFS_REF_SHORT, 32'h4000, 0, 32'h3e8},
        '{32'h2, OFS_REF_SHORT, 32'h2000, 0, 32'h1f4},
        '{32'h2, OFS_REF_SHORT, 32'hc000, 0, 32'hffff_fc18},
        '{32'h6, OFS_REF_LONG, 32'h4000_0000, 0, 32'h3e8},
        '{32'h6, OFS_REF_LONG, 32'hc000_0000, 0, 32'hffff_fc18},
        '{32'h3, OFS_POS_REF, 32'h1234, 1, 32'h2468},
        '{32'h3, OFS_POS_REF, 32'hffff_fff0, 1, 32'hffff_ffe0},
        '{32'h3, OFS_VEL_REF, 32'h100, 2, 32'h80}};
    dsr_codec  i_dut (.*);
    dsr_master i_master (.*);
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_master.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rdc(input logic [7:0] a, input string name, input logic [31:0] exp);
        i_master.xfer(1'b0, a, 32'h0, q, e);
        chk(name, q, exp);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic results();
        $display("Checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        settle(3000);
        errors++;
        results();
    end
    initial begin
        {presetn, measured_speed_native, drive_position_raw, monitor_values} = '0;
        {target_reached, homing_valid, traverse_ack, drive_stopped, remote_location} = '0;
        {status_low, vendor_sources, errors, n_checks} = '0;
        pstrb = 4'hf;
        settle(20);
        presetn <= 1'b1;
        wr(OFS_CONFIG, 32'h2);
        wr(OFS_MAX_REF, 32'h3e8);
        wr(OFS_POS_SCALE, 32'h2_0000);
        wr(OFS_VEL_SCALE, 32'h8000);
        foreach (rows[i]) begin
            wr(OFS_CONFIG, rows[i].cfg);
            wr(rows[i].off, rows[i].data);
            settle(4);
            q = rows[i].sel == 0 ? speed_command : rows[i].sel == 1 ? position_command
                : velocity_command;
            chk("command", q, rows[i].exp);
        end
        $display("Scaling rows done");
        monitor_values <= {64'h0, 32'h1000, 32'h4000_0000};
        drive_position_raw <= 32'h5555;
        wr(OFS_CONFIG, 32'h2);
        settle(4);
        rdc(OFS_ACT_LONG, "act_long", 32'h4000_0000);
        rdc(OFS_ACT_SHORT, "act_short", 32'h4000);
        rdc(OFS_ACT_POS, "act_pos", 32'h5555);
        wr(OFS_CONFIG, 32'h102);
        settle(4);
        rdc(OFS_ACT_LONG, "act_sel", 32'h1000);
        $display("Actual values done");
        {status_low, remote_location, target_reached, homing_valid, traverse_ack} <= {8'ha5, 4'hf};
        wr(OFS_POS_SCALE, 32'h1_0000);
        wr(OFS_CONFIG, 32'h3);
        wr(OFS_POS_REF, 32'h5555);
        settle(6);
        chk("status_hi", status_word[15:8], 8'h1f);
        chk("pos_mode", positioning_mode, 1'b1);
        drive_position_raw <= 32'h6000;
        settle(7);
        rdc(OFS_STATUS, "status_reg", 32'h1ea5);
        vendor_sources <= 8'h08;
        measured_speed_native <= 32'hffff_fc18;
        wr(OFS_SUPERVISION, 32'h64);
        wr(OFS_CONFIG, 32'h0600_0002);
        settle(6);
        chk("status_hi", status_word[15:8], 8'h47);
        chk("tol_flag", within_tolerance_flag, 1'b1);
        measured_speed_native <= 32'h32;
        settle(6);
        chk("status_hi", status_word[15:8], 8'h42);
        $display("Status word done");
        wr(OFS_CONTROL, 32'h1234);
        settle(4);
        chk("control", control_word, 16'h1234);
        pstrb <= 4'h1;
        wr(OFS_CONTROL, 32'h00ff);
        pstrb <= 4'hf;
        settle(4);
        chk("strobe", control_word, 16'h12ff);
        wr(OFS_CONFIG, 32'h0);
        wr(OFS_REF_SHORT, 32'h4000);
        settle(4);
        chk("control", control_word, 16'h0);
        chk("fb_ctrl", fieldbus_control, 1'b0);
        chk("speed", speed_command, 32'hffff_fc18);
        i_master.xfer(1'b1, OFS_STATUS, 32'h0, q, e);
        chk("ro_err", e, 1'b1);
        i_master.xfer(1'b0, 8'h44, 32'h0, q, e);
        chk("map_err", e, 1'b1);
        $display("Gating and refusals done");
        presetn <= 1'b0;
        settle(2);
        chk("status_rst", status_word, 16'h0);
        presetn <= 1'b1;
        rdc(OFS_POS_SCALE, "scale_rst", RST_UNITY);
        rdc(OFS_CONFIG, "cfg_rst", RST_ZERO);
        $display("Reset done");
        results();
    end
endmodule
